// >>> design/mpsc_ctrl.sv
// Core and serial-port power-state controller of the cell monitor
// Contract
// - Separate core and port machines, own timeouts.
// - Sleep only when everything off and expired.
// - Ports held idle while core sleeps.
// - Wake in sleep enters standby, timers run.
// - Conversion or keep-on write settles, then proceeds.
// - Standby sleeps after timers and sleep timeout.
// - Discharge timer disabled: watchdog alone decides.
// - Keep-on write reaches reference-up, reference powered.
// - Reference-up conversion measures without settling.
// - Keep-on cleared leaves reference-up for standby.
// - Measure ends to reference-up or standby.
// - Only conversion or diagnostic commands measure.
// - Port wake: ready delay or wake delay.
// - Ready with no port activity times out idle.
// - Traffic on either port enters active.
// - Port B only on daisy-chain variant.
// - Cell measurement runs both converters.
// - General purpose inputs use one converter.
// - Mode from option bit and mode bits.
// - Measure inputs first, then calibrate channels.
// - Watchdog expiry resets, releases watchdog pin.
module mpsc_ctrl
  import mpsc_pkg::*;
#(
  parameter bit          DAISY_CHAIN  = 1'b1,
  parameter int unsigned SETTLE_CYC   = REF_SETTLE_CYC,
  parameter int unsigned SLEEP_T_CYC  = SLEEP_CYC,
  parameter int unsigned READY_T_CYC  = READY_CYC,
  parameter int unsigned WAKE_T_CYC   = WAKE_CYC,
  parameter int unsigned IDLE_T_CYC   = PORT_IDLE_CYC,
  parameter int unsigned WDT_T_CYC    = WDT_CYC
)(
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  input  wire logic       i_ce,
  input  wire logic       i_wake,
  input  wire logic       i_port_busy,
  input  wire logic       i_cmd_valid,
  input  wire mpsc_cmd_e  i_cmd_kind,
  input  wire logic [1:0] i_cmd_md,
  input  wire logic       i_cfg_write,
  input  wire logic [7:0] i_cfg_byte0,
  input  wire logic       i_sdt_enable,
  input  wire logic       i_sdt_expired,
  input  wire logic       i_meas_done,
  input  wire logic       i_cal_done,
  output mpsc_core_e      o_core_state,
  output mpsc_port_e      o_port_state,
  output logic            o_ref_pwr,
  output logic            o_adc1_en,
  output logic            o_adc2_en,
  output logic            o_adc_cal,
  output mpsc_mode_e      o_adc_mode,
  output logic            o_reference_keep_on,
  output logic            o_port_a_pwr,
  output logic            o_port_b_pwr,
  output logic            o_wdt_o,
  output logic            o_wdt_oe,
  output logic            o_dev_reset
);

  mpsc_core_e core_q, next_core;
  mpsc_port_e port_q, next_port;
  mpsc_cmd_e  kind_q, next_kind;
  mpsc_mode_e next_mode;
  logic [1:0] md_q, next_md;
  logic       reference_keep_on_q, next_reference_keep_on;
  logic       adc_option_select_q, next_adc_option_select;
  logic       pend_q, next_pend;
  logic       cal_q, next_cal;
  logic       slow_q, next_slow;
  logic       wd_exp, wd_exp_d, wd_fire;
  logic       sleep_exp, settle_exp, ready_exp, wake_exp, idle_exp;
  logic       conv_cmd, timers_done;

  // Watchdog, sleep and port-idle timers each own their timeout
  mpsc_timer #(.CYC(WDT_T_CYC)) u_wdt (
    .i_clk_sys (i_clk_sys), .i_rst (i_rst), .i_ce (i_ce),
    .i_load    (i_wake), .o_expired (wd_exp));
  mpsc_timer #(.CYC(SLEEP_T_CYC)) u_sleep (
    .i_clk_sys (i_clk_sys), .i_rst (i_rst), .i_ce (i_ce),
    .i_load    (i_wake), .o_expired (sleep_exp));
  mpsc_timer #(.CYC(SETTLE_CYC)) u_settle (
    .i_clk_sys (i_clk_sys), .i_rst (i_rst), .i_ce (i_ce),
    .i_load    (next_core == CORE_SETTLE && core_q != CORE_SETTLE), .o_expired (settle_exp));
  mpsc_timer #(.CYC(READY_T_CYC)) u_ready (
    .i_clk_sys (i_clk_sys), .i_rst (i_rst), .i_ce (i_ce),
    .i_load    (port_q == PORT_IDLE && i_wake), .o_expired (ready_exp));
  mpsc_timer #(.CYC(WAKE_T_CYC)) u_wake_signal (
    .i_clk_sys (i_clk_sys), .i_rst (i_rst), .i_ce (i_ce),
    .i_load    (port_q == PORT_IDLE && i_wake), .o_expired (wake_exp));
  mpsc_timer #(.CYC(IDLE_T_CYC)) u_idle (
    .i_clk_sys (i_clk_sys), .i_rst (i_rst), .i_ce (i_ce),
    .i_load    (i_wake || i_port_busy), .o_expired (idle_exp));

  // Only conversion and diagnostic commands count
  assign conv_cmd = i_cmd_valid && (i_cmd_kind != CMD_OTHER);
  // Disabled discharge timer leaves the watchdog alone
  assign timers_done = wd_exp && (!i_sdt_enable || i_sdt_expired);
  assign wd_fire = wd_exp && !wd_exp_d;

  // Configuration bits; watchdog expiry is a device reset
  always_comb
  begin
    next_reference_keep_on  = reference_keep_on_q;
    next_adc_option_select = adc_option_select_q;
    if (wd_fire)
    begin
      next_reference_keep_on  = REFERENCE_KEEP_ON_RST;
      next_adc_option_select = ADC_OPTION_SELECT_RST;
    end
    // A host write in the expiry cycle is kept, it is the newer intent
    if (i_cfg_write)
    begin
      next_reference_keep_on  = i_cfg_byte0[CFG_REFERENCE_KEEP_ON_BIT];
      next_adc_option_select = i_cfg_byte0[CFG_ADC_OPTION_SELECT_BIT];
    end
  end

  always_comb
  begin
    next_core = core_q;
    next_pend = pend_q;
    next_kind = kind_q;
    next_cal  = cal_q;
    next_md   = md_q;
    case (core_q)
      CORE_SLEEP:
        if (i_wake)
          next_core = CORE_STANDBY;
      CORE_STANDBY:
        if (conv_cmd || next_reference_keep_on)
        begin
          next_core = CORE_SETTLE;
          next_pend = conv_cmd;
          if (conv_cmd)
          begin
            next_kind = i_cmd_kind;
            next_md   = i_cmd_md;
          end
        end
        else if (timers_done && sleep_exp && !i_wake)
          next_core = CORE_SLEEP;
      CORE_SETTLE:
      begin
        if (conv_cmd && !pend_q)
        begin
          next_pend = 1'b1;
          next_kind = i_cmd_kind;
          next_md   = i_cmd_md;
        end
        if (settle_exp)
          next_core = next_pend ? CORE_MEASURE : CORE_REFERENCE_UP_STATE;
        next_cal = 1'b0;
      end
      CORE_REFERENCE_UP_STATE:
        if (conv_cmd)
        begin
          next_core = CORE_MEASURE;
          next_kind = i_cmd_kind;
          next_md   = i_cmd_md;
          next_cal  = 1'b0;
        end
        else if (!next_reference_keep_on)
          next_core = CORE_STANDBY;
      CORE_MEASURE:
        if (!cal_q && i_meas_done)
          next_cal = 1'b1;
        else if (cal_q && i_cal_done)
        begin
          next_core = reference_keep_on_q ? CORE_REFERENCE_UP_STATE : CORE_STANDBY;
          next_pend = 1'b0;
          next_cal  = 1'b0;
        end
      default:
        next_core = CORE_SLEEP;
    endcase
  end

  always_comb
  begin
    next_port = port_q;
    next_slow = slow_q;
    case (port_q)
      PORT_IDLE:
        if (i_wake)
        begin
          next_port = PORT_WAKING;
          next_slow = (core_q == CORE_SLEEP);
        end
      PORT_WAKING:
        if (slow_q ? wake_exp : ready_exp)
          next_port = PORT_READY;
      PORT_READY:
        if (i_port_busy)
          next_port = PORT_ACTIVE;
        else if (idle_exp && !i_wake)
          next_port = PORT_IDLE;
      PORT_ACTIVE:
        if (!i_port_busy)
          next_port = PORT_READY;
      default:
        next_port = PORT_IDLE;
    endcase
    // Follows the core's next state so both agree in every cycle
    if (next_core == CORE_SLEEP)
      next_port = PORT_IDLE;
  end

  // Mode bits kept from the accepted command, the bus has moved on after settling
  assign next_mode = mpsc_mode(next_adc_option_select, next_md);

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      core_q       <= CORE_SLEEP;
      port_q       <= PORT_IDLE;
      kind_q       <= CMD_OTHER;
      md_q         <= 2'h0;
      reference_keep_on_q      <= REFERENCE_KEEP_ON_RST;
      adc_option_select_q     <= ADC_OPTION_SELECT_RST;
      pend_q       <= 1'b0;
      cal_q        <= 1'b0;
      slow_q       <= 1'b0;
      wd_exp_d     <= 1'b1;
      o_core_state <= CORE_SLEEP;
      o_port_state <= PORT_IDLE;
      o_ref_pwr    <= 1'b0;
      o_adc1_en    <= 1'b0;
      o_adc2_en    <= 1'b0;
      o_adc_cal    <= 1'b0;
      o_adc_mode   <= MODE_7KHZ;
      o_reference_keep_on      <= REFERENCE_KEEP_ON_RST;
      o_port_a_pwr <= 1'b0;
      o_port_b_pwr <= 1'b0;
      o_wdt_o      <= 1'b0;
      o_wdt_oe     <= 1'b0;
      o_dev_reset  <= 1'b0;
    end
    else if (i_ce)
    begin
      core_q       <= next_core;
      port_q       <= next_port;
      kind_q       <= next_kind;
      md_q         <= next_md;
      reference_keep_on_q      <= next_reference_keep_on;
      adc_option_select_q     <= next_adc_option_select;
      pend_q       <= next_pend;
      cal_q        <= next_cal;
      slow_q       <= next_slow;
      wd_exp_d     <= wd_exp;
      o_core_state <= next_core;
      o_port_state <= next_port;
      // Reference stays up in reference-up and measure only
      o_ref_pwr    <= (next_core == CORE_REFERENCE_UP_STATE) || (next_core == CORE_MEASURE);
      o_adc1_en    <= (next_core == CORE_MEASURE);
      o_adc2_en    <= (next_core == CORE_MEASURE) && (next_kind != CMD_GPIO);
      o_adc_cal    <= (next_core == CORE_MEASURE) && next_cal;
      if (next_core == CORE_MEASURE && core_q != CORE_MEASURE)
        o_adc_mode <= next_mode;
      o_reference_keep_on      <= next_reference_keep_on;
      o_port_a_pwr <= (next_port == PORT_READY) || (next_port == PORT_ACTIVE);
      // Addressable variant has no second port
      o_port_b_pwr <= DAISY_CHAIN && ((next_port == PORT_READY) || (next_port == PORT_ACTIVE));
      o_wdt_oe     <= !wd_exp;
      o_dev_reset  <= wd_fire;
    end
  end

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  sequence s_into_sleep;
    (core_q != CORE_SLEEP) ##1 (core_q == CORE_SLEEP);
  endsequence
  sequence s_into_measure;
    (core_q != CORE_MEASURE) ##1 (core_q == CORE_MEASURE);
  endsequence
  property p_sleep_entry;
    s_into_sleep |-> $past(timers_done) && $past(sleep_exp);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep without expiry");

  property p_port_idle_sleep;
    core_q == CORE_SLEEP |-> port_q == PORT_IDLE && !o_port_a_pwr;
  endproperty
  a_port_idle_sleep: assert property (p_port_idle_sleep) else $error("port up in sleep");

  property p_wake;
    i_ce && i_wake && core_q == CORE_SLEEP |=> core_q == CORE_STANDBY;
  endproperty
  a_wake: assert property (p_wake) else $error("wake did not reach standby");

  property p_settle_hold;
    core_q == CORE_SETTLE && !settle_exp |=> core_q == CORE_SETTLE;
  endproperty
  a_settle_hold: assert property (p_settle_hold) else $error("settle cut short");

  property p_reference_up_state_measure;
    i_ce && core_q == CORE_REFERENCE_UP_STATE && conv_cmd |=> core_q == CORE_MEASURE ##1 o_adc1_en;
  endproperty
  a_reference_up_state_measure: assert property (p_reference_up_state_measure) else $error("reference_up_state not direct");

  property p_reference_up_state_leave;
    i_ce && core_q == CORE_REFERENCE_UP_STATE && !conv_cmd && !next_reference_keep_on |=> core_q == CORE_STANDBY;
  endproperty
  a_reference_up_state_leave: assert property (p_reference_up_state_leave) else $error("reference_up_state held");

  property p_measure_end;
    i_ce && core_q == CORE_MEASURE && cal_q && i_cal_done
      |=> core_q == ($past(reference_keep_on_q) ? CORE_REFERENCE_UP_STATE : CORE_STANDBY);
  endproperty
  a_measure_end: assert property (p_measure_end) else $error("wrong state after measure");

  property p_measure_cause;
    s_into_measure |-> $past(conv_cmd) || $past(pend_q);
  endproperty
  a_measure_cause: assert property (p_measure_cause) else $error("measure without command");

  property p_port_timeout;
    i_ce && port_q == PORT_READY && idle_exp && !i_port_busy && !i_wake
      |=> port_q == PORT_IDLE ##1 !o_port_a_pwr;
  endproperty
  a_port_timeout: assert property (p_port_timeout) else $error("ready did not time out");

  property p_gpio_one;
    o_adc1_en && kind_q == CMD_GPIO |-> !o_adc2_en;
  endproperty
  a_gpio_one: assert property (p_gpio_one) else $error("gpio used two converters");

  property p_wdt_release;
    i_ce && wd_exp |=> !o_wdt_oe;
  endproperty
  a_wdt_release: assert property (p_wdt_release) else $error("watchdog pin driven");

endmodule : mpsc_ctrl

// >>> design/mpsc_timer.sv
// Reloadable down-counting timeout with registered expiry flag
module mpsc_timer
  import mpsc_pkg::*;
#(
  parameter int unsigned CYC = 16,
  parameter int unsigned W   = $clog2(CYC + 1)
)(
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  input  wire logic i_ce,
  input  wire logic i_load,
  output logic      o_expired
);

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic         next_expired;

  always_comb
  begin
    next_cnt = cnt;
    if (i_load)
      next_cnt = W'(CYC);
    else if (cnt != '0)
      next_cnt = cnt - 1'b1;
    next_expired = (next_cnt == '0);
  end

  // Starts expired so nothing is pending out of reset
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt       <= '0;
      o_expired <= 1'b1;
    end
    else if (i_ce)
    begin
      cnt       <= next_cnt;
      o_expired <= next_expired;
    end
  end

endmodule : mpsc_timer

// >>> pkg/mpsc_pkg.sv
// Constants, types and helpers shared by the power-state controller
package mpsc_pkg;

  localparam int unsigned CLK_FREQ_MHZ = 200;

  // Times in their own unit, cycle counts derived below
  localparam longint unsigned REF_SETTLE_TIME_US = 64'd5000;
  localparam longint unsigned SLEEP_TIMEOUT_MS   = 64'd1000;
  localparam longint unsigned READY_DELAY_US     = 64'd10;
  localparam longint unsigned WAKE_DELAY_US      = 64'd100;
  localparam longint unsigned PORT_IDLE_TIME_US  = 64'd5500;
  localparam longint unsigned WDT_TIMEOUT_S      = 64'd2;

  // Least times round up, longest times round down, never below one cycle
  function automatic int unsigned mpsc_cyc_up(input longint unsigned t_ns);
    longint unsigned c;
    c = (t_ns * CLK_FREQ_MHZ + 64'd999) / 64'd1000;
    return (c < 64'd1) ? 1 : int'(c);
  endfunction : mpsc_cyc_up

  function automatic int unsigned mpsc_cyc_dn(input longint unsigned t_ns);
    longint unsigned c;
    c = (t_ns * CLK_FREQ_MHZ) / 64'd1000;
    return (c < 64'd1) ? 1 : int'(c);
  endfunction : mpsc_cyc_dn

  localparam int unsigned REF_SETTLE_CYC = mpsc_cyc_up(REF_SETTLE_TIME_US * 64'd1000);
  localparam int unsigned SLEEP_CYC      = mpsc_cyc_up(SLEEP_TIMEOUT_MS * 64'd1000000);
  localparam int unsigned READY_CYC      = mpsc_cyc_dn(READY_DELAY_US * 64'd1000);
  localparam int unsigned WAKE_CYC       = mpsc_cyc_dn(WAKE_DELAY_US * 64'd1000);
  localparam int unsigned PORT_IDLE_CYC  = mpsc_cyc_up(PORT_IDLE_TIME_US * 64'd1000);
  localparam int unsigned WDT_CYC        = mpsc_cyc_up(WDT_TIMEOUT_S * 64'd1000000000);

  // config_byte_zero field positions and reset values
  localparam int unsigned CFG_ADC_OPTION_SELECT_BIT = 0;
  localparam int unsigned CFG_REFERENCE_KEEP_ON_BIT  = 2;
  localparam logic        REFERENCE_KEEP_ON_RST      = 1'b0;
  localparam logic        ADC_OPTION_SELECT_RST     = 1'b0;

  typedef enum logic [2:0] {
    CORE_SLEEP,
    CORE_STANDBY,
    CORE_SETTLE,
    CORE_REFERENCE_UP_STATE,
    CORE_MEASURE
  } mpsc_core_e;

  typedef enum logic [1:0] {
    PORT_IDLE,
    PORT_WAKING,
    PORT_READY,
    PORT_ACTIVE
  } mpsc_port_e;

  typedef enum logic [1:0] {
    CMD_OTHER,
    CMD_CELL,
    CMD_GPIO,
    CMD_DIAG
  } mpsc_cmd_e;

  typedef enum logic [2:0] {
    MODE_27KHZ,
    MODE_14KHZ,
    MODE_7KHZ,
    MODE_3KHZ,
    MODE_2KHZ,
    MODE_26HZ
  } mpsc_mode_e;

  // Six oversampling modes from option bit and two mode bits
  function automatic mpsc_mode_e mpsc_mode(input logic opt, input logic [1:0] md);
    mpsc_mode_e m;
    m = MODE_7KHZ;
    if (md == 2'h1)
      m = opt ? MODE_14KHZ : MODE_27KHZ;
    else if (md == 2'h2)
      m = opt ? MODE_3KHZ : MODE_7KHZ;
    else if (md == 2'h3)
      m = opt ? MODE_2KHZ : MODE_26HZ;
    return m;
  endfunction : mpsc_mode

endpackage : mpsc_pkg

// >>> sim/mpsc_ctrl_tb.sv
// Self-checking bench for the power-state controller
module mpsc_ctrl_tb;
  import mpsc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int SETTLE = 8;
  localparam int SLP    = 40;
  localparam int WK     = 12;
  localparam int IDL    = 30;
  localparam int WDT    = 60;
  localparam int RDY    = 5;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic pa_addr, pb_addr;
  logic meas_done = 1'b0;
  logic cal_done = 1'b0;
  logic sdt_en = 1'b0;
  logic sdt_exp = 1'b0;
  logic wake, busy, cmd_valid, cfg_wr;
  mpsc_cmd_e cmd_kind;
  logic [1:0] cmd_md;
  logic [7:0] cfg_b0;
  mpsc_core_e core;
  mpsc_port_e port;
  logic ref_pwr, adc1, adc2, adc_cal, reference_keep_on, pa_pwr, pb_pwr, wdt_o, wdt_oe, dev_rst;
  mpsc_mode_e mode;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  int n_rst = 0;

  always #2.5 clk = ~clk;

  mpsc_host_model host (.i_clk_sys(clk), .o_wake(wake), .o_busy(busy),
    .o_cmd_valid(cmd_valid), .o_cmd_kind(cmd_kind), .o_cmd_md(cmd_md),
    .o_cfg_write(cfg_wr), .o_cfg_byte0(cfg_b0));

  mpsc_ctrl #(.DAISY_CHAIN(1'b1), .SETTLE_CYC(SETTLE), .SLEEP_T_CYC(SLP), .WAKE_T_CYC(WK),
    .READY_T_CYC(RDY), .IDLE_T_CYC(IDL), .WDT_T_CYC(WDT)) dut (.i_clk_sys(clk), .i_rst(rst),
    .i_ce(ce),
    .i_wake(wake), .i_port_busy(busy), .i_cmd_valid(cmd_valid), .i_cmd_kind(cmd_kind),
    .i_cmd_md(cmd_md), .i_cfg_write(cfg_wr), .i_cfg_byte0(cfg_b0), .i_sdt_enable(sdt_en),
    .i_sdt_expired(sdt_exp), .i_meas_done(meas_done), .i_cal_done(cal_done),
    .o_core_state(core), .o_port_state(port), .o_ref_pwr(ref_pwr), .o_adc1_en(adc1),
    .o_adc2_en(adc2), .o_adc_cal(adc_cal), .o_adc_mode(mode), .o_reference_keep_on(reference_keep_on),
    .o_port_a_pwr(pa_pwr), .o_port_b_pwr(pb_pwr), .o_wdt_o(wdt_o), .o_wdt_oe(wdt_oe),
    .o_dev_reset(dev_rst));

  // Addressable variant shares every input; only its port powers are judged
  mpsc_ctrl #(.DAISY_CHAIN(1'b0), .SETTLE_CYC(SETTLE), .SLEEP_T_CYC(SLP), .WAKE_T_CYC(WK),
    .READY_T_CYC(RDY), .IDLE_T_CYC(IDL), .WDT_T_CYC(WDT)) dut_addr (.i_clk_sys(clk),
    .i_rst(rst), .i_ce(ce), .i_wake(wake), .i_port_busy(busy), .i_cmd_valid(cmd_valid),
    .i_cmd_kind(cmd_kind), .i_cmd_md(cmd_md), .i_cfg_write(cfg_wr), .i_cfg_byte0(cfg_b0),
    .i_sdt_enable(sdt_en), .i_sdt_expired(sdt_exp), .i_meas_done(meas_done),
    .i_cal_done(cal_done), .o_core_state(), .o_port_state(), .o_ref_pwr(), .o_adc1_en(),
    .o_adc2_en(), .o_adc_cal(), .o_adc_mode(), .o_reference_keep_on(), .o_port_a_pwr(pa_addr),
    .o_port_b_pwr(pb_addr), .o_wdt_o(), .o_wdt_oe(), .o_dev_reset());

  task automatic close_out();
    if (miscompares == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out

  // Generous ceiling; the whole sequence needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (dev_rst === 1'b1)
      n_rst++;
    if (cycles == 8000)
    begin
      miscompares++;
      close_out();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic step();
    @(posedge clk);
    #1;
  endtask : step

  // Poll under a bound; the count lets callers judge the latency
  task automatic wait_core(input mpsc_core_e s, input int lim, output int n);
    n = 0;
    while (core !== s && n < lim)
    begin
      step();
      n++;
    end
    check(8'(core), 8'(s));
  endtask : wait_core

  task automatic wait_port(input mpsc_port_e s, input int lim, output int n);
    n = 0;
    while (port !== s && n < lim)
    begin
      step();
      n++;
    end
    check(8'(port), 8'(s));
  endtask : wait_port

  task automatic finish_conv(input mpsc_core_e after);
    int n;
    step();
    meas_done = 1'b1;
    step();
    meas_done = 1'b0;
    repeat (2) step();
    check(8'(adc_cal), 8'h01);
    cal_done = 1'b1;
    step();
    cal_done = 1'b0;
    wait_core(after, 3, n);
    check(8'(adc1), 8'h00);
  endtask : finish_conv

  task automatic t_reset();
    check(8'(core), 8'(CORE_SLEEP));
    check(8'(port), 8'(PORT_IDLE));
    check({ref_pwr, adc1, adc2, pa_pwr, reference_keep_on}, 8'h00);
    check(8'(mode), 8'(MODE_7KHZ));
  endtask : t_reset

  task automatic t_wake();
    int n;
    host.wake();
    wait_core(CORE_STANDBY, 3, n);
    check({ref_pwr, adc1, adc2}, 8'h00);
    wait_port(PORT_READY, WK + 6, n);
    check(8'(n >= WK - 3), 8'h01);
    check(8'(wdt_oe), 8'h01);
    check({pa_pwr, pb_pwr, pa_addr, pb_addr}, 8'h0e);
    host.set_busy(1'b1);
    wait_port(PORT_ACTIVE, 3, n);
    host.set_busy(1'b0);
    wait_port(PORT_READY, 3, n);
    wait_port(PORT_IDLE, IDL + 5, n);
    check(8'(n >= IDL - 5), 8'h01);
    // Core is awake now, so the short ready delay applies
    host.wake();
    wait_port(PORT_READY, RDY + 4, n);
    check(8'(n <= RDY + 2), 8'h01);
  endtask : t_wake

  task automatic t_conv();
    int n;
    host.wake();
    host.command(CMD_OTHER, 2'h1);
    repeat (3) step();
    check(8'(core), 8'(CORE_STANDBY));
    host.command(CMD_CELL, 2'h1);
    wait_core(CORE_MEASURE, SETTLE + 5, n);
    check(8'(n >= SETTLE - 2), 8'h01);
    check({ref_pwr, adc1, adc2, adc_cal}, 8'h0e);
    check(8'(mode), 8'(MODE_27KHZ));
    finish_conv(CORE_STANDBY);
  endtask : t_conv

  task automatic t_reference_up_state();
    mpsc_mode_e exp_mode [6] = '{MODE_27KHZ, MODE_7KHZ, MODE_26HZ,
                                 MODE_14KHZ, MODE_3KHZ, MODE_2KHZ};
    mpsc_cmd_e kind;
    int n;
    host.wake();
    host.cfg_write(8'h04);
    wait_core(CORE_REFERENCE_UP_STATE, SETTLE + 5, n);
    check({ref_pwr, adc1, adc2, reference_keep_on}, 8'h09);
    for (int i = 0; i < 6; i++)
    begin
      kind = (i == 0) ? CMD_GPIO : ((i % 2) ? CMD_DIAG : CMD_CELL);
      host.wake();
      host.cfg_write({7'h02, 1'(i / 3)});
      host.command(kind, 2'(i % 3 + 1));
      wait_core(CORE_MEASURE, 2, n);
      check(8'(mode), 8'(exp_mode[i]));
      check({adc1, adc2}, {6'h00, 1'b1, 1'(i != 0)});
      finish_conv(CORE_REFERENCE_UP_STATE);
    end
    host.cfg_write(8'h00);
    wait_core(CORE_STANDBY, 3, n);
  endtask : t_reference_up_state

  task automatic t_sleep();
    int n;
    int r0;
    sdt_en = 1'b1;
    r0 = n_rst;
    host.wake();
    repeat (WDT + 20) step();
    check(8'(core), 8'(CORE_STANDBY));
    check(8'(n_rst - r0), 8'h01);
    check(8'(wdt_oe), 8'h00);
    check(8'(wdt_o), 8'h00);
    sdt_exp = 1'b1;
    wait_core(CORE_SLEEP, 4, n);
    check(8'(port), 8'(PORT_IDLE));
    sdt_en = 1'b0;
    sdt_exp = 1'b0;
    host.wake();
    wait_core(CORE_STANDBY, 3, n);
    wait_core(CORE_SLEEP, WDT + 10, n);
    check(8'(n >= WDT - 4), 8'h01);
  endtask : t_sleep

  // Clock enable low must swallow a wake entirely
  task automatic t_freeze();
    int n;
    ce = 1'b0;
    host.wake();
    repeat (3) step();
    check({4'(core), 4'(port)}, 8'h00);
    ce = 1'b1;
    host.wake();
    wait_core(CORE_STANDBY, 3, n);
  endtask : t_freeze

  initial
  begin
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_wake();
    t_conv();
    t_reference_up_state();
    t_sleep();
    t_freeze();
    close_out();
  end
endmodule : mpsc_ctrl_tb

// >>> sim/mpsc_host_model.sv
// Host controller model driving wake, traffic, command and configuration strobes
module mpsc_host_model
  import mpsc_pkg::*;
(
  input  wire logic  i_clk_sys,
  output logic       o_wake,
  output logic       o_busy,
  output logic       o_cmd_valid,
  output mpsc_cmd_e  o_cmd_kind,
  output logic [1:0] o_cmd_md,
  output logic       o_cfg_write,
  output logic [7:0] o_cfg_byte0
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    o_wake      = 1'b0;
    o_busy      = 1'b0;
    o_cmd_valid = 1'b0;
    o_cmd_kind  = CMD_OTHER;
    o_cmd_md    = 2'h0;
    o_cfg_write = 1'b0;
    o_cfg_byte0 = 8'h00;
  end

  task automatic step();
    @(posedge i_clk_sys);
    #1;
  endtask : step

  task automatic wake();
    step();
    o_wake = 1'b1;
    step();
    o_wake = 1'b0;
  endtask : wake

  task automatic set_busy(input logic lvl);
    step();
    o_busy = lvl;
  endtask : set_busy

  // Qualifiers flip once released so stale values never look valid
  task automatic command(input mpsc_cmd_e kind, input logic [1:0] md);
    step();
    o_cmd_valid = 1'b1;
    o_cmd_kind  = kind;
    o_cmd_md    = md;
    step();
    o_cmd_valid = 1'b0;
    o_cmd_kind  = mpsc_cmd_e'(~kind);
    o_cmd_md    = ~md;
  endtask : command

  // Keep-on only ever set through a configuration write
  task automatic cfg_write(input logic [7:0] b);
    step();
    o_cfg_write = 1'b1;
    o_cfg_byte0 = b;
    step();
    o_cfg_write = 1'b0;
    o_cfg_byte0 = ~b;
  endtask : cfg_write
endmodule : mpsc_host_model
